/* i2cs_pkg.sv */
// Purpose: shared constants and types of the two-wire slave register port
// Assumes: 25 MHz system clock, open-drain data line with external pull-up
// Notes:   all offsets, field values and timing counts live here
package i2cs_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_NS    = 40;  // system clock period in ns
    localparam int SPIKE_NS  = 50;  // widest spike the input filter removes
    // least time, so round up to whole cycles
    localparam int FILT_CYC_I = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] FILT_CYC = 2'(FILT_CYC_I);

    // ------------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_HI   = 5'h0a;  // fixed upper address bits 01010
    localparam logic [6:0] FIFO_ADDR = 7'h05;  // register address of the fifo port
    localparam logic [3:0] BYTE_BITS = 4'h8;   // bits per byte on the wire
    localparam logic [7:0] MEM_RST   = 8'h00;  // read data after reset

    // ------------------------------------------------------------------
    // protocol engine states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,  // bus free
        ST_ADDR     = 3'h1,  // shifting slave address byte
        ST_ACK_ADDR = 3'h2,  // driving ack of address
        ST_RX       = 3'h3,  // receiving a byte from the host
        ST_ACK_RX   = 3'h4,  // driving ack of a received byte
        ST_TX       = 3'h5,  // sending a byte to the host
        ST_ACK_TX   = 3'h6,  // sampling the host ack
        ST_IGNORE   = 3'h7   // not addressed, wait for start or stop
    } i2cs_state_t;

endpackage : i2cs_pkg

/* i2cs_glitch_filt.sv */
// Purpose: two-flop synchroniser and spike filter for one bus line
// Assumes: line idles high
// Notes:   output only follows a level that held for the filter length
`timescale 1ns/1ps
module i2cs_glitch_filt (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // control
    input  wire logic filt_en,    // filter active
    // line
    input  wire logic line_i,     // raw pin level
    output logic      line_q      // synchronised, filtered level
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic       s1_q;             // first sync stage, read only by s2
    logic       s2_q;             // second sync stage
    logic [1:0] cnt_q, cnt_d;     // stability counter
    logic       line_d;           // next filtered level

    // next filtered level and counter
    always_comb begin
        line_d = line_q;
        cnt_d  = 2'h0;
        if (!filt_en) begin
            line_d = s2_q;        // bypass when disabled
        end else if (s2_q != line_q) begin
            if (cnt_q == i2cs_pkg::FILT_CYC - 2'h1) begin
                line_d = s2_q;    // level held long enough
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            cnt_q  <= 2'h0;
            line_q <= 1'b1;
        end else begin
            s1_q   <= line_i;
            s2_q   <= s1_q;
            cnt_q  <= cnt_d;
            line_q <= line_d;
        end
    end

endmodule : i2cs_glitch_filt

/* i2cs_regmem.sv */
// Purpose: register store behind the two-wire port
// Assumes: one write and one read port, same clock
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/1ps
module i2cs_regmem (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // write port
    input  wire logic       we,      // write strobe
    input  wire logic [6:0] waddr,   // write address
    input  wire logic [7:0] wdata,   // write data
    // read port
    input  wire logic [6:0] raddr,   // read address
    output logic      [7:0] rdata_q  // registered read data
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] mem [0:127];         // register array, no reset

    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= i2cs_pkg::MEM_RST;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule : i2cs_regmem

/* i2cs_port.sv */
// Purpose: slave-only two-wire host port to internal registers and fifo
// Assumes: host masters the bus; scl and sda sampled by the 25 MHz clock
// Notes:   device never drives scl; sda is open drain (oe high pulls low)
`timescale 1ns/1ps
module i2cs_port (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // configuration
    input  wire logic       if_sel,        // two-wire port is the host interface
    input  wire logic       adr_from_pins, // low address bits from pins, else nv
    input  wire logic [1:0] nv_adr,        // low address bits from nv setting
    // pins
    input  wire logic [1:0] adr_pins,      // address select pins
    input  wire logic       scl_i,         // serial clock, input only
    input  wire logic       sda_i,         // serial data level
    output logic            sda_o,         // serial data drive level
    output logic            sda_oe,        // serial data pull-low enable
    // fifo
    output logic            fifo_push,     // one-cycle push strobe
    output logic      [7:0] fifo_wdata,    // data pushed
    output logic            fifo_pop,      // one-cycle pop strobe
    input  wire logic [7:0] fifo_rdata,    // fifo head
    // status
    output logic            bus_busy       // between start and stop
);

    // ------------------------------------------------------------------
    // line conditioning
    // ------------------------------------------------------------------
    logic scl_f;                      // filtered clock level
    logic sda_f;                      // filtered data level

    // spike filters follow the interface selection, short enough for fast plus
    i2cs_glitch_filt u_scl_filt (
        .clk     (clk),
        .rstn    (rstn),
        .filt_en (if_sel),
        .line_i  (scl_i),
        .line_q  (scl_f)
    );

    i2cs_glitch_filt u_sda_filt (
        .clk     (clk),
        .rstn    (rstn),
        .filt_en (if_sel),
        .line_i  (sda_i),
        .line_q  (sda_f)
    );

    // ------------------------------------------------------------------
    // address select pins
    // ------------------------------------------------------------------
    logic [1:0] adr_s1_q;             // first sync stage
    logic [1:0] adr_s2_q;             // second sync stage
    logic [6:0] own_addr;             // complete slave address

    // two-flop sync of the address pins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            adr_s1_q <= 2'h0;
            adr_s2_q <= 2'h0;
        end else begin
            adr_s1_q <= adr_pins;
            adr_s2_q <= adr_s1_q;
        end
    end

    // fixed upper bits, low bits from pins or nv setting
    assign own_addr = {i2cs_pkg::ADDR_HI, adr_from_pins ? adr_s2_q : nv_adr};

    // ------------------------------------------------------------------
    // bus condition detection
    // ------------------------------------------------------------------
    logic scl_p_q;                    // clock level one cycle ago
    logic sda_p_q;                    // data level one cycle ago
    logic start_c;                    // start or repeated start seen
    logic stop_c;                     // stop seen
    logic scl_rise;                   // clock rising edge
    logic scl_fall;                   // clock falling edge

    // previous levels for edge finding
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // sda edges while scl is high mark start and stop
    assign start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;

    // ------------------------------------------------------------------
    // pointer step
    // ------------------------------------------------------------------
    // fifo address holds, all others advance by one
    function automatic logic [6:0] next_ptr(input logic [6:0] p);
        next_ptr = (p == i2cs_pkg::FIFO_ADDR) ? p : p + 7'h01;
    endfunction : next_ptr

    // ------------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------------
    i2cs_pkg::i2cs_state_t st_q, st_d;   // engine state
    logic [3:0] cnt_q, cnt_d;            // bit counter
    logic [7:0] sh_q, sh_d;              // shift register
    logic [6:0] ptr_q, ptr_d;            // register pointer
    logic       rw_q, rw_d;              // direction bit of the frame
    logic       first_q, first_d;        // next byte is register address
    logic       ackd_q, ackd_d;          // host acked, load next byte
    logic       oe_q, oe_d;              // sda pull-low enable
    logic       busy_q, busy_d;          // bus busy
    logic       push_q, push_d;          // fifo push strobe
    logic [7:0] fdat_q, fdat_d;          // fifo push data
    logic       pop_q, pop_d;            // fifo pop strobe
    logic       we_q, we_d;              // register write strobe
    logic [6:0] wa_q, wa_d;              // register write address
    logic [7:0] wd_q, wd_d;              // register write data
    logic [7:0] mem_rdata;               // register read data
    logic [7:0] tx_src;                  // byte to send next

    // register store, read continuously at the pointer
    i2cs_regmem u_mem (
        .clk     (clk),
        .rstn    (rstn),
        .we      (we_q),
        .waddr   (wa_q),
        .wdata   (wd_q),
        .raddr   (ptr_q),
        .rdata_q (mem_rdata)
    );

    // read data come from the fifo head at the fifo address
    assign tx_src = (ptr_q == i2cs_pkg::FIFO_ADDR) ? fifo_rdata : mem_rdata;

    // next state of the engine
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        first_d = first_q;
        ackd_d  = ackd_q;
        oe_d    = oe_q;
        busy_d  = busy_q;
        push_d  = 1'b0;
        fdat_d  = fdat_q;
        pop_d   = 1'b0;
        we_d    = 1'b0;
        wa_d    = wa_q;
        wd_d    = wd_q;
        if (!if_sel) begin
            // port not selected: stay off the bus
            st_d   = i2cs_pkg::ST_IDLE;
            oe_d   = 1'b0;
            busy_d = 1'b0;
        end else if (start_c) begin
            // start and repeated start alike, bus stays busy
            st_d   = i2cs_pkg::ST_ADDR;
            cnt_d  = 4'h0;
            ackd_d = 1'b0;
            oe_d   = 1'b0;
            busy_d = 1'b1;
        end else if (stop_c) begin
            // stop frees the bus
            st_d   = i2cs_pkg::ST_IDLE;
            oe_d   = 1'b0;
            busy_d = 1'b0;
        end else begin
            case (st_q)
                i2cs_pkg::ST_ADDR: begin
                    // address byte, msb first, sampled on rise
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_f};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == i2cs_pkg::BYTE_BITS) begin
                        cnt_d = 4'h0;
                        // general call and id query never match
                        if (sh_q[7:1] == own_addr) begin
                            rw_d = sh_q[0];
                            oe_d = 1'b1;             // ack the address
                            st_d = i2cs_pkg::ST_ACK_ADDR;
                        end else begin
                            st_d = i2cs_pkg::ST_IGNORE; // stay released
                        end
                    end
                end
                i2cs_pkg::ST_ACK_ADDR: begin
                    // end of address ack, turn to read or write
                    if (scl_fall) begin
                        if (rw_q) begin
                            // read returns the addressed register
                            sh_d  = tx_src;
                            pop_d = (ptr_q == i2cs_pkg::FIFO_ADDR);
                            oe_d  = ~tx_src[7];       // msb first
                            st_d  = i2cs_pkg::ST_TX;
                        end else begin
                            // write frame: register address comes first
                            oe_d    = 1'b0;
                            first_d = 1'b1;
                            st_d    = i2cs_pkg::ST_RX;
                        end
                    end
                end
                i2cs_pkg::ST_RX: begin
                    // receive a byte, ack it on the falling edge
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_f};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == i2cs_pkg::BYTE_BITS) begin
                        cnt_d = 4'h0;
                        oe_d  = 1'b1;                 // receiver pulls low
                        st_d  = i2cs_pkg::ST_ACK_RX;
                        if (first_q) begin
                            ptr_d   = sh_q[6:0];      // register address
                            first_d = 1'b0;
                        end else if (ptr_q == i2cs_pkg::FIFO_ADDR) begin
                            push_d = 1'b1;            // into fifo, no step
                            fdat_d = sh_q;
                        end else begin
                            we_d  = 1'b1;             // store and step
                            wa_d  = ptr_q;
                            wd_d  = sh_q;
                            ptr_d = next_ptr(ptr_q);
                        end
                    end
                end
                i2cs_pkg::ST_ACK_RX: begin
                    // release after the ack pulse
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        st_d = i2cs_pkg::ST_RX;
                    end
                end
                i2cs_pkg::ST_TX: begin
                    // send a byte, change data only after scl falls
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == i2cs_pkg::BYTE_BITS) begin
                            cnt_d  = 4'h0;
                            oe_d   = 1'b0;            // release for host ack
                            ackd_d = 1'b0;
                            st_d   = i2cs_pkg::ST_ACK_TX;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];          // next bit, msb first
                        end
                    end
                end
                i2cs_pkg::ST_ACK_TX: begin
                    // sample host ack; nack ends the read
                    if (scl_rise) begin
                        if (sda_f) begin
                            st_d = i2cs_pkg::ST_IGNORE;
                        end else begin
                            ackd_d = 1'b1;
                            ptr_d  = next_ptr(ptr_q); // step, fifo holds
                        end
                    end else if (scl_fall && ackd_q) begin
                        ackd_d = 1'b0;
                        sh_d   = tx_src;
                        pop_d  = (ptr_q == i2cs_pkg::FIFO_ADDR);
                        oe_d   = ~tx_src[7];
                        st_d   = i2cs_pkg::ST_TX;
                    end
                end
                i2cs_pkg::ST_IGNORE: begin
                    // wait for next start or stop, sda released
                    oe_d = 1'b0;
                end
                default: begin
                    // idle: nothing driven, lines rest high
                    st_d = i2cs_pkg::ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // engine registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q    <= i2cs_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 7'h00;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
            ackd_q  <= 1'b0;
            oe_q    <= 1'b0;
            busy_q  <= 1'b0;
            push_q  <= 1'b0;
            fdat_q  <= 8'h00;
            pop_q   <= 1'b0;
            we_q    <= 1'b0;
            wa_q    <= 7'h00;
            wd_q    <= 8'h00;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            first_q <= first_d;
            ackd_q  <= ackd_d;
            oe_q    <= oe_d;
            busy_q  <= busy_d;
            push_q  <= push_d;
            fdat_q  <= fdat_d;
            pop_q   <= pop_d;
            we_q    <= we_d;
            wa_q    <= wa_d;
            wd_q    <= wd_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic sda_lo_q;                   // open-drain level, always low

    // no scl driver exists at all: slave only, no stretching
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sda_lo_q <= 1'b0;
        end else begin
            sda_lo_q <= 1'b0;
        end
    end

    assign sda_o      = sda_lo_q;
    assign sda_oe     = oe_q;
    assign fifo_push  = push_q;
    assign fifo_wdata = fdat_q;
    assign fifo_pop   = pop_q;
    assign bus_busy   = busy_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_start_addr: assert property (@(posedge clk) disable iff (!rstn)
        (if_sel && start_c) |=> (st_q == i2cs_pkg::ST_ADDR && busy_q))
        else $error("start not taken");

    a_stop_free: assert property (@(posedge clk) disable iff (!rstn)
        (if_sel && !start_c && stop_c) |=> (st_q == i2cs_pkg::ST_IDLE && !busy_q))
        else $error("stop did not free bus");

    a_ack_match: assert property (@(posedge clk) disable iff (!rstn)
        (if_sel && !start_c && !stop_c && st_q == i2cs_pkg::ST_ADDR && scl_fall
         && cnt_q == i2cs_pkg::BYTE_BITS && sh_q[7:1] == own_addr) |=> oe_q)
        else $error("own address not acked");

    a_ignore_free: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == i2cs_pkg::ST_IGNORE || st_q == i2cs_pkg::ST_IDLE) |-> ##1 !oe_q)
        else $error("sda driven while not addressed");

    a_drive_low: assert property (@(posedge clk) disable iff (!rstn)
        $rose(oe_q) |-> !$past(scl_f))
        else $error("sda drive started with scl high");

    a_fifo_hold: assert property (@(posedge clk) disable iff (!rstn)
        push_q |-> (ptr_q == i2cs_pkg::FIFO_ADDR && fdat_q == $past(sh_q)))
        else $error("fifo push moved pointer");

    a_write_step: assert property (@(posedge clk) disable iff (!rstn)
        we_q |-> (ptr_q == wa_q + 7'h01 && wa_q != i2cs_pkg::FIFO_ADDR))
        else $error("write did not step pointer");

    a_host_ack: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == i2cs_pkg::ST_ACK_TX && $past(st_q) == i2cs_pkg::ST_ACK_TX) |-> !oe_q)
        else $error("sda held during host ack");

    a_no_gcall: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == i2cs_pkg::ST_ADDR && scl_fall && cnt_q == i2cs_pkg::BYTE_BITS
         && sh_q[7:1] == 7'h00 && !start_c && !stop_c) |=> !oe_q)
        else $error("general call acked");

endmodule : i2cs_port

/* i2cs_host_model.sv */
// Purpose: host master model for the two-wire bus
// Assumes: pull-up on data line, 320 ns bit period
// Notes:   blocking tasks, called by the bench
`timescale 1ns/1ps
module i2cs_host_model (
    // bus
    output logic      scl,     // clock, host only
    output logic      sda_low, // host pulls data low
    input  wire logic sda      // resolved data level
);
    // idle: both lines high, clock still
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit: long low phase covers the slave's sync and filter delay
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #40 sda_low = ~b;
        #160 scl = 1'b1;
        #60 r = sda;
        #60;
    endtask : bit_io
    // start, or repeated start when rep is set
    task automatic start(input logic rep);
        if (rep) begin
            scl = 1'b0;
            #40 sda_low = 1'b0;
            #160 scl = 1'b1;
            #120;
        end
        sda_low = 1'b1;
        #160;
    endtask : start
    // stop: data rises while clock high, then bus free long enough to settle
    task automatic stop();
        scl = 1'b0;
        #40 sda_low = 1'b1;
        #160 scl = 1'b1;
        #120 sda_low = 1'b0;
        #240;
    endtask : stop
    // send a byte msb first, release for ack
    task automatic wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wb
    // read a byte, ack or withhold ack
    task automatic rb(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask : rb
endmodule : i2cs_host_model

/* i2c_host_slave_register_port_tb_top.sv */
// Purpose: self-checking bench of the two-wire slave port
// Assumes: address pins 01, nv address bits 00
// Notes:   host model drives the bus
`timescale 1ns/1ps
module i2c_host_slave_register_port_tb_top;
    logic clk = 1'b0, rstn = 1'b0, oe, push, pop, busy, a;
    logic [7:0] wdat, d, last;
    logic sel = 1'b1, frompins = 1'b1;      // port select, address source
    logic [7:0] head = 8'h5a;               // fifo head seen by the port
    int fail_count = 0, cmp_count = 0, pushes = 0, pops = 0;
    wire scl, low, sda_o;
    wire sda = ~(low | oe);                 // open drain with pull-up
    localparam logic [7:0] DW = 8'h52, DR = 8'h53; // own address 0101001
    always #20 clk = ~clk;
    i2cs_host_model i_i2cs_host_model (.scl(scl), .sda_low(low), .sda(sda));
    i2cs_port i_i2cs_port (.clk(clk), .rstn(rstn), .if_sel(sel), .adr_from_pins(frompins),
        .nv_adr(2'h0), .adr_pins(2'h1), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(oe), .fifo_push(push), .fifo_wdata(wdat), .fifo_pop(pop),
        .fifo_rdata(head), .bus_busy(busy));
    // count fifo strobes
    always @(posedge clk) begin
        if (push === 1'b1) begin pushes++; last = wdat; end
        if (pop === 1'b1) pops++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    // set register address with a write frame
    task automatic set_ptr(input logic [7:0] p, input logic rep);
        i_i2cs_host_model.start(rep);
        i_i2cs_host_model.wb(DW, a); chk(a, 1);
        i_i2cs_host_model.wb(p, a); chk(a, 1);
    endtask : set_ptr
    task automatic t_write_read();
        set_ptr(8'h10, 0);
        chk(busy, 1);
        chk(sda_o, 0);
        i_i2cs_host_model.wb(8'ha5, a); chk(a, 1);
        i_i2cs_host_model.wb(8'h3c, a); chk(a, 1);
        i_i2cs_host_model.stop();
        chk(busy, 0);
        set_ptr(8'h10, 0);
        i_i2cs_host_model.start(1);
        i_i2cs_host_model.wb(DR, a); chk(a, 1);
        i_i2cs_host_model.rb(1, d); chk(d, 8'ha5);
        i_i2cs_host_model.rb(0, d); chk(d, 8'h3c);
        i_i2cs_host_model.stop();
    endtask : t_write_read
    task automatic t_fifo();
        set_ptr(8'h05, 0);
        i_i2cs_host_model.wb(8'h11, a);
        i_i2cs_host_model.wb(8'h22, a);
        chk(pushes, 2); chk(last, 8'h22);
        set_ptr(8'h05, 1);
        i_i2cs_host_model.start(1);
        i_i2cs_host_model.wb(DR, a);
        i_i2cs_host_model.rb(1, d); chk(d, 8'h5a);
        head = 8'h6b;
        i_i2cs_host_model.rb(0, d); chk(d, 8'h6b); chk(pops, 2);
        i_i2cs_host_model.stop();
    endtask : t_fifo
    task automatic t_foreign(input logic [7:0] ad);
        i_i2cs_host_model.start(0);
        i_i2cs_host_model.wb(ad, a); chk(a, 0);
        i_i2cs_host_model.wb(8'h00, a); chk(a, 0);
        i_i2cs_host_model.stop();
    endtask : t_foreign
    // address bits from the nv setting, then a deselected port
    task automatic t_config();
        frompins = 1'b0;
        i_i2cs_host_model.start(0);
        i_i2cs_host_model.wb(8'h50, a); chk(a, 1);
        i_i2cs_host_model.stop();
        t_foreign(DW);
        frompins = 1'b1;
        sel = 1'b0;
        t_foreign(DW);
        sel = 1'b1;
    endtask : t_config
    initial begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (8) @(posedge clk);
        #1 t_write_read();
        t_fifo();
        t_foreign(8'h00); t_foreign(8'hf8); t_foreign(8'h56); t_foreign(8'h54);
        t_config();
        test_done();
    end
    // watchdog, run needs about 100 us
    initial begin
        #2000000 fail_count++;
        test_done();
    end
endmodule : i2c_host_slave_register_port_tb_top
